// [logic/kbc_host_ec_byte_mailbox.sv]
// Functional notes
// - Host status read at 04h mirrors controller status; host cannot write it.
// - Bits 7:6,4,2 written only by controller; bit 2 on host reset.
// - Aux write sets aux-full; controller data write clears it.
// - Host write at 04h marks command; write at 0h marks data.
// - Any host data or command byte taken while host_wr_ready is high sets input-full.
// - Input-full raises enabled input irq; controller read clears both.
// - Input and output full flags survive power-well reset; read clears.
// - Controller data or aux write sets output-full.
// - Host data read clears output-full and pulses output-empty irq.
// - Controller registers at 100h, 104h, 108h, 10Ch and 114h.
// - Controller read of 100h returns host bytes in arrival order, one mailbox byte at a time.
// - Host data read clears aux output irq too, and keyboard irq unless direct select is on.
`timescale 1ns/1ps
module kbc_host_ec_byte_mailbox
  import kbc_mailbox_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic host_rst,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [HOST_ADDR_W-1:0] host_addr,
  input wire logic [BYTE_W-1:0] host_wdata,
  output logic [BYTE_W-1:0] host_rdata,
  output logic host_wr_ready,
  input wire logic ec_wr,
  input wire logic ec_rd,
  input wire logic [EC_ADDR_W-1:0] ec_addr,
  input wire logic [BYTE_W-1:0] ec_wdata,
  output logic [BYTE_W-1:0] ec_rdata,
  input wire logic input_irq_en,
  output logic input_irq,
  output logic output_empty_irq,
  output logic kbd_irq,
  output logic aux_irq
);
  function automatic logic ec_hit(input logic [EC_ADDR_W-1:0] a,
                                  input logic [EC_ADDR_W-1:0] o);
    return a == o;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [BYTE_W-1:0] in_byte_ff;
  logic [BYTE_W-1:0] out_byte_ff;
  logic [BYTE_W-1:0] ctrl_ff;
  logic [1:0] user_high_ff;
  logic user_mid_ff;
  logic user_low_ff;
  logic cmd_ff;
  logic aux_full_ff;
  logic direct_ff;
  logic [BYTE_W-1:0] host_rdata_ff;
  logic [BYTE_W-1:0] ec_rdata_ff;
  logic input_irq_ff;
  logic empty_irq_ff;
  logic kbd_irq_ff;
  logic aux_irq_ff;
  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_clr;
  logic [FLAG_N-1:0] flag_q;
  logic [FLAG_N-1:0] flag_nxt;

  mailbox_stream_if #(.W(FIFO_W)) in_q ();

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  wire host_wr_data = host_wr & (host_addr == HOST_DATA_OFS);
  wire host_wr_cmd = host_wr & (host_addr == HOST_STATUS_OFS);
  wire host_rd_data = host_rd & (host_addr == HOST_DATA_OFS);
  wire host_rd_stat = host_rd & (host_addr == HOST_STATUS_OFS);
  wire ec_rd_in = ec_rd & ec_hit(ec_addr, CONTROLLER_OUTPUT_BYTE_OFS);
  wire ec_wr_out = ec_wr & ec_hit(ec_addr, CONTROLLER_OUTPUT_BYTE_OFS);
  wire ec_wr_stat = ec_wr & ec_hit(ec_addr, EC_STATUS_OFS);
  wire ec_wr_ctrl = ec_wr & ec_hit(ec_addr, EC_CTRL_OFS);
  wire ec_wr_aux = ec_wr & ec_hit(ec_addr, EC_AUX_OFS);
  wire ec_wr_direct = ec_wr & ec_hit(ec_addr, EC_DIRECT_OFS);
  wire ec_wr_any_out = ec_wr_out | ec_wr_aux;

  // One status byte serves both sides
  wire [BYTE_W-1:0] status = {user_high_ff, aux_full_ff, user_mid_ff,
                              cmd_ff, user_low_ff, flag_q[FL_IN],
                              flag_q[FL_OUT]};

  // ------------------------------------------------------------
  // Host byte queue
  // ------------------------------------------------------------
  // Command mark travels with the byte
  assign in_q.push_valid = host_wr_data | host_wr_cmd;
  assign in_q.push_data = {host_wr_cmd, host_wdata};
  // Only one byte in the mailbox; later ones wait in the queue
  assign in_q.pop_ready = ~flag_q[FL_IN];
  wire in_load = in_q.pop_valid & in_q.pop_ready;

  byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_in_fifo (
    .clock(clock),
    .srst(srst),
    .s(in_q)
  );

  // ------------------------------------------------------------
  // Sticky flags
  // ------------------------------------------------------------
  // Loaded host byte sets input-full
  assign flag_set[FL_IN] = in_load;
  assign flag_clr[FL_IN] = ec_rd_in;
  // Data or aux write sets output-full
  assign flag_set[FL_OUT] = ec_wr_any_out;
  assign flag_clr[FL_OUT] = host_rd_data;
  // Host data read drops both output irq flags
  assign flag_set[FL_KBD] = ec_wr_out;
  assign flag_clr[FL_KBD] = host_rd_data;
  assign flag_set[FL_AUX] = ec_wr_aux;
  assign flag_clr[FL_AUX] = host_rd_data;
  assign flag_nxt = flag_set | (flag_q & ~flag_clr);

  // Flags see only system reset, never power-well reset
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
      set_clear_flag u_flag (
        .clock(clock),
        .srst(srst),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read muxes
  // ------------------------------------------------------------
  wire [BYTE_W-1:0] host_rd_mux = host_rd_stat ? status :
                                  host_rd_data ? out_byte_ff : BYTE_RST;
  // Read of 100h gives the host byte held in the mailbox
  wire [BYTE_W-1:0] ec_rd_mux =
    ec_hit(ec_addr, CONTROLLER_OUTPUT_BYTE_OFS) ? in_byte_ff :
    ec_hit(ec_addr, EC_STATUS_OFS) ? status :
    ec_hit(ec_addr, EC_CTRL_OFS) ? ctrl_ff :
    ec_hit(ec_addr, EC_DIRECT_OFS) ? {7'h00, direct_ff} : BYTE_RST;
  wire kbd_src = ctrl_ff[CT_DIRECT_SEL] ? direct_ff : flag_nxt[FL_KBD];
  // Aux bit writable by firmware only when hardware does not own it
  wire aux_sw_wr = ec_wr_stat & ~ctrl_ff[CT_AUX_HW];
  // Aux write sets, data write clears
  wire nxt_aux_full = ec_wr_aux ? 1'b1 :
                      ec_wr_out ? 1'b0 :
                      aux_sw_wr ? ec_wdata[ST_AUX_FULL] : aux_full_ff;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      in_byte_ff <= BYTE_RST;
      cmd_ff <= FLAG_RST;
    end else if (in_load) begin
      in_byte_ff <= in_q.pop_data[BYTE_W-1:0];
      cmd_ff <= in_q.pop_data[FIFO_CMD_BIT];
    end
  end

  // Data and aux share the host-visible output byte
  always_ff @(posedge clock) begin
    if (srst) begin
      out_byte_ff <= BYTE_RST;
    end else if (ec_wr_any_out) begin
      out_byte_ff <= ec_wdata;
    end
  end

  // User bits change only by controller writes
  always_ff @(posedge clock) begin
    if (srst) begin
      user_high_ff <= USER_HIGH_RST;
      user_mid_ff <= FLAG_RST;
    end else if (ec_wr_stat) begin
      user_high_ff <= ec_wdata[ST_USER_HIGH +: 2];
      user_mid_ff <= ec_wdata[ST_USER_MID];
    end
  end

  // Low user bit follows host reset
  always_ff @(posedge clock) begin
    if (srst | host_rst) begin
      user_low_ff <= FLAG_RST;
    end else if (ec_wr_stat) begin
      user_low_ff <= ec_wdata[ST_USER_LOW];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      aux_full_ff <= FLAG_RST;
      ctrl_ff <= CTRL_RST;
      direct_ff <= FLAG_RST;
    end else begin
      aux_full_ff <= nxt_aux_full;
      ctrl_ff <= ec_wr_ctrl ? ec_wdata : ctrl_ff;
      direct_ff <= ec_wr_direct ? ec_wdata[0] : direct_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      host_rdata_ff <= BYTE_RST;
      ec_rdata_ff <= BYTE_RST;
    end else begin
      host_rdata_ff <= host_rd ? host_rd_mux : host_rdata_ff;
      ec_rdata_ff <= ec_rd ? ec_rd_mux : ec_rdata_ff;
    end
  end

  // Input, aux and, without direct select, kbd irqs follow the next flag state to avoid an extra cycle of lag
  always_ff @(posedge clock) begin
    if (srst) begin
      input_irq_ff <= FLAG_RST;
      empty_irq_ff <= FLAG_RST;
      kbd_irq_ff <= FLAG_RST;
      aux_irq_ff <= FLAG_RST;
    end else begin
      input_irq_ff <= flag_nxt[FL_IN] & input_irq_en;
      empty_irq_ff <= host_rd_data;
      kbd_irq_ff <= ctrl_ff[CT_OUT_IRQ_EN] & kbd_src;
      aux_irq_ff <= ctrl_ff[CT_OUT_IRQ_EN] & flag_nxt[FL_AUX];
    end
  end

  assign host_rdata = host_rdata_ff;
  assign host_wr_ready = in_q.push_ready;
  assign ec_rdata = ec_rdata_ff;
  assign input_irq = input_irq_ff;
  assign output_empty_irq = empty_irq_ff;
  assign kbd_irq = kbd_irq_ff;
  assign aux_irq = aux_irq_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_out_write;
    ec_wr_out && !ec_wr_aux;
  endsequence
  sequence s_host_drain;
    host_rd_data && !ec_wr_any_out && !ctrl_ff[CT_DIRECT_SEL]
      ##1 !ec_wr_any_out;
  endsequence
  sequence s_cmd_write;
    host_wr_cmd && in_q.push_ready && !in_q.pop_valid
      && !flag_q[FL_IN];
  endsequence
  sequence s_data_write;
    host_wr_data && in_q.push_ready && !in_q.pop_valid
      && !flag_q[FL_IN];
  endsequence

  property p_status_mirror;
    host_rd_stat |=> host_rdata == $past(status);
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("host status view differs from status");
  property p_user_hold;
    !ec_wr_stat && !host_rst |=> $stable(status[ST_USER_HIGH +: 2])
      && $stable(status[ST_USER_LOW]) && $stable(status[ST_USER_MID]);
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("user bits moved without controller write");
  property p_aux_clear;
    s_out_write |=> !aux_full_ff;
  endproperty
  a_aux_clear: assert property (p_aux_clear)
    else $error("aux full not cleared by data write");
  property p_aux_set;
    ec_wr_aux |=> aux_full_ff && flag_q[FL_OUT];
  endproperty
  a_aux_set: assert property (p_aux_set)
    else $error("aux write did not set aux and output full");
  property p_cmd_mark;
    s_cmd_write |-> ##2 cmd_ff && flag_q[FL_IN];
  endproperty
  a_cmd_mark: assert property (p_cmd_mark)
    else $error("command byte not marked within two cycles");
  property p_in_full;
    in_load |=> flag_q[FL_IN] && in_byte_ff == $past(in_q.pop_data[7:0]);
  endproperty
  a_in_full: assert property (p_in_full)
    else $error("loaded host byte did not set input full");
  property p_in_clear;
    ec_rd_in && !in_load |=> !flag_q[FL_IN] && !input_irq;
  endproperty
  a_in_clear: assert property (p_in_clear)
    else $error("controller read left input full or irq");
  property p_out_full;
    ec_wr_any_out |=> flag_q[FL_OUT] && out_byte_ff == $past(ec_wdata);
  endproperty
  a_out_full: assert property (p_out_full)
    else $error("output write did not set output full");
  property p_out_empty;
    host_rd_data && !ec_wr_any_out |=> !flag_q[FL_OUT] && output_empty_irq;
  endproperty
  a_out_empty: assert property (p_out_empty)
    else $error("host data read did not empty output");
  property p_ctrl_map;
    ec_wr_ctrl ##1 (ec_rd && ec_hit(ec_addr, EC_CTRL_OFS) && !ec_wr)
      |=> ec_rdata == $past(ec_wdata, 2);
  endproperty
  a_ctrl_map: assert property (p_ctrl_map)
    else $error("control register not at its offset");
  property p_ec_read;
    ec_rd_in |=> ec_rdata == $past(in_byte_ff);
  endproperty
  a_ec_read: assert property (p_ec_read)
    else $error("controller read did not return host byte");
  property p_irq_drop;
    s_host_drain |=> !kbd_irq && !aux_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("output irqs survived host data read");
  property p_loop_byte;
    s_out_write ##1 (host_rd_data && !ec_wr_any_out)
      |=> host_rdata == $past(ec_wdata, 2);
  endproperty
  a_loop_byte: assert property (p_loop_byte)
    else $error("host did not read controller data byte");
  property p_data_mark;
    s_data_write |-> ##2 !cmd_ff && flag_q[FL_IN];
  endproperty
  a_data_mark: assert property (p_data_mark)
    else $error("data byte not marked within two cycles");
  property p_user_low_rst;
    host_rst |=> !user_low_ff;
  endproperty
  a_user_low_rst: assert property (p_user_low_rst)
    else $error("host reset left low user bit set");
  property p_in_irq;
    flag_q[FL_IN] && input_irq_en && !ec_rd_in |=> input_irq;
  endproperty
  a_in_irq: assert property (p_in_irq)
    else $error("input irq low while input full and enabled");
endmodule // kbc_host_ec_byte_mailbox

// [logic/kbc_mailbox_pkg.sv]
package kbc_mailbox_pkg;
  localparam int BYTE_W = 8;
  localparam int HOST_ADDR_W = 3;
  localparam int EC_ADDR_W = 9;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 4;
  // ------------------------------------------------------------
  // Host side offsets
  // ------------------------------------------------------------
  localparam logic [2:0] HOST_DATA_OFS = 3'h0;
  localparam logic [2:0] HOST_STATUS_OFS = 3'h4;
  // ------------------------------------------------------------
  // Controller side offsets
  // ------------------------------------------------------------
  localparam logic [8:0] CONTROLLER_OUTPUT_BYTE_OFS = 9'h100;
  localparam logic [8:0] EC_STATUS_OFS = 9'h104;
  localparam logic [8:0] EC_CTRL_OFS = 9'h108;
  localparam logic [8:0] EC_AUX_OFS = 9'h10C;
  localparam logic [8:0] EC_DIRECT_OFS = 9'h114;
  // ------------------------------------------------------------
  // Status and control fields
  // ------------------------------------------------------------
  localparam int ST_OUT_FULL = 0;
  localparam int ST_IN_FULL = 1;
  localparam int ST_USER_LOW = 2;
  localparam int ST_CMD = 3;
  localparam int ST_USER_MID = 4;
  localparam int ST_AUX_FULL = 5;
  localparam int ST_USER_HIGH = 6;
  localparam int CT_AUX_HW = 7;
  localparam int CT_OUT_IRQ_EN = 5;
  localparam int CT_DIRECT_SEL = 2;
  localparam int FIFO_CMD_BIT = 8;
  // ------------------------------------------------------------
  // Sticky flag slots and reset values
  // ------------------------------------------------------------
  localparam int FL_IN = 0;
  localparam int FL_OUT = 1;
  localparam int FL_KBD = 2;
  localparam int FL_AUX = 3;
  localparam int FLAG_N = 4;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] USER_HIGH_RST = 2'h0;
  localparam logic FLAG_RST = 1'b0;
endpackage

// [logic/mailbox_stream_if.sv]
`timescale 1ns/1ps
interface mailbox_stream_if #(parameter int W = 9);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fill(output push_valid, output push_data, input push_ready);
  modport store(input push_valid, input push_data, input pop_ready,
                output push_ready, output pop_valid, output pop_data);
  modport drain(input pop_valid, input pop_data, output pop_ready);
endinterface

// [logic/byte_fifo.sv]
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic srst,
  mailbox_stream_if.store s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic ready_ff;
  wire push = s.push_valid & ready_ff;
  wire pop = s.pop_valid & s.pop_ready;
  wire [AW:0] nxt_count = count_ff + {{AW{1'b0}}, push}
                        - {{AW{1'b0}}, pop};
  assign s.push_ready = ready_ff;
  assign s.pop_valid = (count_ff != '0);
  assign s.pop_data = mem[rd_ptr_ff];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= s.push_data;
    end
  end
  // Ready is registered so the top output comes from a flop
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff <= pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      count_ff <= nxt_count;
      ready_ff <= (nxt_count < FULL_COUNT);
    end
  end
endmodule // byte_fifo

// [logic/set_clear_flag.sv]
`timescale 1ns/1ps
module set_clear_flag
  import kbc_mailbox_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // Set wins so a same-cycle event is never lost
  wire nxt_q = set | (q & ~clr);
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= FLAG_RST;
    end else begin
      q <= nxt_q;
    end
  end
  property p_set_wins;
    @(posedge clock) disable iff (srst) set |=> q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost a set that met a clear");
endmodule // set_clear_flag

// [tb/host_cpu_model.sv]
`timescale 1ns/1ps
module host_cpu_model
  import kbc_mailbox_pkg::*;
(
  input wire logic clock,
  input wire logic host_wr_ready,
  output logic host_wr,
  output logic host_rd,
  output logic [HOST_ADDR_W-1:0] host_addr,
  output logic [BYTE_W-1:0] host_wdata
);
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 3'h0;
    host_wdata = 8'h00;
  end

  // Bounded wait on ready, so a full queue never hangs the host
  task automatic wr(input logic [2:0] a, input logic [7:0] d,
                    output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      @(negedge clock);
      if (host_wr_ready === 1'b1) begin
        ok = 1'b1;
      end
    end
    if (ok) begin
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clock);
      host_wr = 1'b0;
      // Released data line shows the inverse, not the last byte
      host_wdata = ~d;
    end
  endtask

  task automatic rd(input logic [2:0] a);
    @(negedge clock);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    host_rd = 1'b0;
  endtask
endmodule // host_cpu_model

// [tb/test_kbc_host_ec_byte_mailbox.sv]
`timescale 1ns/1ps
module test_kbc_host_ec_byte_mailbox;
  import kbc_mailbox_pkg::*;
  logic clock, srst, host_rst, host_wr, host_rd, host_wr_ready;
  logic [2:0] host_addr;
  logic [7:0] host_wdata, host_rdata, ec_wdata, ec_rdata;
  logic ec_wr, ec_rd, input_irq_en, input_irq;
  logic output_empty_irq, kbd_irq, aux_irq;
  logic [8:0] ec_addr;
  logic h_pend, e_pend, ok;
  logic [7:0] d, x, n_ok;
  logic [7:0] b [8];
  logic [7:0] q [$];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  kbc_host_ec_byte_mailbox uut (.clock(clock), .srst(srst),
    .host_rst(host_rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_wr_ready(host_wr_ready),
    .ec_wr(ec_wr), .ec_rd(ec_rd), .ec_addr(ec_addr),
    .ec_wdata(ec_wdata), .ec_rdata(ec_rdata),
    .input_irq_en(input_irq_en), .input_irq(input_irq),
    .output_empty_irq(output_empty_irq), .kbd_irq(kbd_irq),
    .aux_irq(aux_irq));
  host_cpu_model host (.clock(clock), .host_wr_ready(host_wr_ready),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata));

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Read data lands one edge after the strobe
  always @(posedge clock) begin
    h_pend <= host_rd;
    e_pend <= ec_rd;
  end
  always @(negedge clock) begin
    if (h_pend === 1'b1) begin
      check(host_rdata, q.pop_front());
    end
    if (e_pend === 1'b1) begin
      check(ec_rdata, q.pop_front());
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic ec_w(input logic [8:0] a, input logic [7:0] v);
    @(negedge clock);
    ec_addr = a;
    ec_wdata = v;
    ec_wr = 1'b1;
    @(negedge clock);
    ec_wr = 1'b0;
    ec_wdata = ~v;
  endtask

  task automatic ec_r(input logic [8:0] a, input logic [7:0] e);
    q.push_back(e);
    @(negedge clock);
    ec_addr = a;
    ec_rd = 1'b1;
    @(negedge clock);
    ec_rd = 1'b0;
  endtask

  task automatic h_r(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e);
    host.rd(a);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  initial begin
    srst = 1'b1;
    host_rst = 1'b0;
    ec_wr = 1'b0;
    ec_rd = 1'b0;
    ec_addr = 9'h000;
    ec_wdata = 8'h00;
    input_irq_en = 1'b1;
    void'($urandom(51));
    wait_n(20);
    srst = 1'b0;
    wait_n(3);
    h_r(HOST_STATUS_OFS, 8'h00);
    ec_r(CONTROLLER_OUTPUT_BYTE_OFS, 8'h00);
    ec_r(EC_CTRL_OFS, 8'h00);
    $display("test reset done");

    d = 8'($urandom);
    host.wr(HOST_DATA_OFS, d, ok);
    wait_n(2);
    check({7'h00, input_irq}, 8'h01);
    h_r(HOST_STATUS_OFS, 8'h02);
    ec_r(CONTROLLER_OUTPUT_BYTE_OFS, d);
    wait_n(1);
    check({7'h00, input_irq}, 8'h00);
    h_r(HOST_STATUS_OFS, 8'h00);
    d = 8'($urandom);
    host.wr(HOST_STATUS_OFS, d, ok);
    wait_n(2);
    h_r(HOST_STATUS_OFS, 8'h0A);
    ec_r(CONTROLLER_OUTPUT_BYTE_OFS, d);
    h_r(HOST_STATUS_OFS, 8'h08);
    $display("test input done");

    // Flag bits 3,1,0 must ignore this write
    ec_w(EC_STATUS_OFS, 8'hFF);
    h_r(HOST_STATUS_OFS, 8'hFC);
    ec_r(EC_STATUS_OFS, 8'hFC);
    @(negedge clock);
    host_rst = 1'b1;
    @(negedge clock);
    host_rst = 1'b0;
    h_r(HOST_STATUS_OFS, 8'hF8);
    ec_w(EC_STATUS_OFS, 8'h00);
    h_r(HOST_STATUS_OFS, 8'h08);
    $display("test user bits done");

    ec_w(EC_CTRL_OFS, 8'h20);
    ec_r(EC_CTRL_OFS, 8'h20);
    ec_w(EC_AUX_OFS, 8'($urandom));
    wait_n(2);
    check({7'h00, aux_irq}, 8'h01);
    h_r(HOST_STATUS_OFS, 8'h29);
    x = 8'($urandom);
    ec_w(CONTROLLER_OUTPUT_BYTE_OFS, x);
    wait_n(2);
    check({7'h00, kbd_irq}, 8'h01);
    h_r(HOST_STATUS_OFS, 8'h09);
    h_r(HOST_DATA_OFS, x);
    check({7'h00, output_empty_irq}, 8'h01);
    wait_n(1);
    check({7'h00, output_empty_irq}, 8'h00);
    check({6'h00, kbd_irq, aux_irq}, 8'h00);
    h_r(HOST_STATUS_OFS, 8'h08);
    $display("test output done");

    ec_w(EC_CTRL_OFS, 8'h24);
    ec_w(EC_DIRECT_OFS, 8'hFF);
    ec_r(EC_DIRECT_OFS, 8'h01);
    wait_n(2);
    check({7'h00, kbd_irq}, 8'h01);
    ec_w(EC_DIRECT_OFS, 8'h00);
    wait_n(2);
    check({7'h00, kbd_irq}, 8'h00);
    ec_w(EC_CTRL_OFS, 8'h00);
    $display("test direct done");

    // Controller stalls while the host fills mailbox and queue
    input_irq_en = 1'b0;
    n_ok = 8'h00;
    for (int i = 0; i < 7; i++) begin
      d = 8'($urandom);
      host.wr(HOST_DATA_OFS, d, ok);
      if (ok) begin
        b[n_ok] = d;
        n_ok++;
      end
    end
    check(n_ok, 8'(FIFO_DEPTH + 1));
    check({7'h00, input_irq}, 8'h00);
    input_irq_en = 1'b1;
    wait_n(2);
    check({7'h00, input_irq}, 8'h01);
    for (int i = 0; i < int'(n_ok); i++) begin
      ec_r(CONTROLLER_OUTPUT_BYTE_OFS, b[i]);
      wait_n(3);
    end
    h_r(HOST_STATUS_OFS, 8'h00);
    check({7'h00, host_wr_ready}, 8'h01);
    $display("test fifo done");

    ec_r(9'h118, 8'h00);
    ec_r(EC_AUX_OFS, 8'h00);
    h_r(3'h2, 8'h00);
    wait_n(2);
    $display("test refuse done");
    close_out();
  end
endmodule // test_kbc_host_ec_byte_mailbox
